/* File: verilog/tsb_top.sv */
`timescale 1ns/10ps
`include "tsb_regs.svh"
module tsb_top #(
  parameter bit HAS_TIMEOUT = 1'b1,
  parameter int unsigned CONV_CYCLES = `TSB_CONV_MS * `TSB_NS_PER_MS / `TSB_CLK_NS,
  parameter int unsigned TOUT_CYCLES = (`TSB_TOUT_MIN_MS * `TSB_NS_PER_MS + `TSB_CLK_NS - 1) / `TSB_CLK_NS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // address straps
  input wire logic [2:0] address_select_pins_i,
  // converter sample, same clock domain
  input wire tsb_pkg::tsb_temp_t adc_sample_i,
  // status
  output logic os_o,
  output tsb_pkg::tsb_temp_t temp_o,
  output logic conv_busy_o
);
  import tsb_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [2:0] adr_m_q, adr_s_q;

  // two flops per pin; only the second stage and its delayed copy feed logic
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      adr_m_q <= 3'h0;
      adr_s_q <= 3'h0;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      adr_m_q <= address_select_pins_i;
      adr_s_q <= adr_m_q;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev, tout_ev;
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_ev = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
  assign stop_ev = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

  // ----------------------------------------
  // register file and serial target
  // ----------------------------------------
  tsb_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, msb_q, msb_d, cfg_q, cfg_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] byte_q, byte_d, ptr_q, ptr_d;
  logic rd_q, rd_d, oe_n_q, oe_n_d, busy_q, busy_d, rdhit;
  tsb_temp_t temp_q, tos_q, tos_d, hyst_q, hyst_d;
  logic [15:0] tx_word;

  // read word for the current pointer, left aligned as on the wire
  always_comb
  begin
    case (ptr_q)
      `TSB_PTR_TEMP: tx_word = {temp_q, 7'h00}; // see [R1] see [R11]
      `TSB_PTR_CFG: tx_word = {cfg_q, cfg_q};
      `TSB_PTR_THYST: tx_word = {hyst_q, 7'h00};
      default: tx_word = {tos_q, 7'h00};
    endcase
  end

  // bit level target: sample on scl rise, change sda on scl fall
  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    rd_d = rd_q;
    oe_n_d = oe_n_q;
    busy_d = busy_q;
    ptr_d = ptr_q;
    cfg_d = cfg_q;
    msb_d = msb_q;
    tos_d = tos_q;
    hyst_d = hyst_q;
    rdhit = 1'b0;
    if (tout_ev) // see [R7]
    begin
      st_d = ST_IDLE;
      oe_n_d = 1'b1;
      busy_d = 1'b0;
    end
    else if (stop_ev) // see [R15]
    begin
      st_d = ST_IDLE;
      oe_n_d = 1'b1;
      busy_d = 1'b0;
    end
    else if (start_ev)
    begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_n_d = 1'b1;
    end
    else
    begin
      case (st_q)
        ST_ADDR, ST_WBYTE:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            if (st_q == ST_WBYTE)
            begin
              st_d = ST_WACK;
              oe_n_d = 1'b0;
              byte_d = byte_q + 2'h1;
              if (byte_q == 2'h0)
                ptr_d = sh_q[1:0];
              else if (ptr_q == `TSB_PTR_CFG)
                cfg_d = sh_q;
              else if (byte_q == 2'h1)
                msb_d = sh_q;
              else if (ptr_q == `TSB_PTR_TOS)
                tos_d = {msb_q, sh_q[7]};
              else if (ptr_q == `TSB_PTR_THYST)
                hyst_d = {msb_q, sh_q[7]};
            end
            else if (sh_q[7:1] == {`TSB_ADDR_HI, adr_s_q}) // see [R10]
            begin
              st_d = ST_AACK;
              oe_n_d = 1'b0;
              rd_d = sh_q[0];
              busy_d = 1'b1; // see [R2]
            end
            else
              st_d = ST_IDLE;
          end
        end
        ST_AACK, ST_WACK, ST_RACK:
        begin
          // a master nack ends the read; the byte after it is not sent
          if (scl_rise && st_q == ST_RACK && sda_s_q)
            st_d = ST_IDLE;
          else if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (st_q == ST_AACK)
              byte_d = 2'h0;
            if (st_q == ST_AACK && rd_q)
              rdhit = 1'b1;
            if (rd_q)
            begin
              st_d = ST_RBYTE;
              // byte_q[0] set means the low byte goes out next
              sh_d = (st_q == ST_AACK || !byte_q[0]) ? tx_word[15:8] : tx_word[7:0];
              byte_d = (st_q == ST_AACK) ? 2'h1 : {1'b0, ~byte_q[0]};
              oe_n_d = (st_q == ST_AACK || !byte_q[0]) ? tx_word[15] : tx_word[7];
            end
            else
            begin
              st_d = ST_WBYTE;
              oe_n_d = 1'b1;
            end
          end
        end
        ST_RBYTE:
        begin
          if (scl_fall)
          begin
            if (cnt_q == 4'h7)
            begin
              st_d = ST_RACK;
              oe_n_d = 1'b1;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_n_d = sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        default:
          oe_n_d = 1'b1;
      endcase
    end
  end

  // serial target registers; limits come up at their defaults
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      oe_n_q <= 1'b1;
      busy_q <= 1'b0;
      ptr_q <= `TSB_PTR_TEMP;
      cfg_q <= `TSB_CFG_RST;
      msb_q <= 8'h00;
      tos_q <= `TSB_TOS_RST; // see [R9]
      hyst_q <= `TSB_THYST_RST; // see [R9]
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      rd_q <= rd_d;
      oe_n_q <= oe_n_d;
      busy_q <= busy_d;
      ptr_q <= ptr_d;
      cfg_q <= cfg_d;
      msb_q <= msb_d;
      tos_q <= tos_d;
      hyst_q <= hyst_d;
    end
  end

  // ----------------------------------------
  // stuck bus timeout
  // ----------------------------------------
  tsb_timeout #(
    .TOUT_CYCLES(TOUT_CYCLES)
  ) u_tout (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(HAS_TIMEOUT && !cfg_q[`TSB_CFG_SHDN]), // see [R13] see [R8]
    .sda_lvl_i(sda_s_q),
    .expire_o(tout_ev)
  );

  // ----------------------------------------
  // conversion sequencer and overtemp
  // ----------------------------------------
  logic [31:0] cv_q, cv_d;
  logic done, shdn, over, under;
  logic [2:0] fq_q, fq_d, fq_need;
  logic act_q, act_d, pend_q, pend_d, os_q, os_d;
  tsb_temp_t temp_d;

  assign shdn = cfg_q[`TSB_CFG_SHDN];
  assign done = !busy_q && !shdn && cv_q == CONV_CYCLES - 32'h1;
  assign over = adc_sample_i > tos_q;
  assign under = adc_sample_i < hyst_q;

  // queue depth select: 1, 2, 4 or 6 consecutive faults
  always_comb
  begin
    case (cfg_q[`TSB_CFG_FQ_HI:`TSB_CFG_FQ_LO])
      2'h0: fq_need = 3'h1;
      2'h1: fq_need = 3'h2;
      2'h2: fq_need = 3'h4;
      default: fq_need = 3'(`TSB_FQ_MAX); // see [R6]
    endcase
  end

  // a bus access holds the counter at zero, so the next conversion is whole
  always_comb
  begin
    cv_d = cv_q + 32'h1;
    temp_d = temp_q;
    fq_d = fq_q;
    act_d = act_q;
    pend_d = pend_q;
    if (busy_q || shdn || done) // see [R2] see [R3]
      cv_d = 32'h0;
    if (done)
    begin
      temp_d = adc_sample_i; // see [R4] see [R1]
      if ((!act_q && over) || (act_q && under))
      begin
        if (fq_q + 3'h1 >= fq_need) // see [R6]
        begin
          fq_d = 3'h0;
          act_d = !act_q;
          pend_d = 1'b1;
        end
        else
          fq_d = fq_q + 3'h1;
      end
      else
        fq_d = 3'h0; // see [R12]
    end
    // interrupt mode: a read or shutdown clears the latched event
    if (rdhit || shdn)
      pend_d = 1'b0;
    if (done && fq_d == 3'h0 && act_d != act_q)
      pend_d = 1'b1;
    os_d = (cfg_q[`TSB_CFG_INTM] ? pend_d : act_d) ^ !cfg_q[`TSB_CFG_POL];
  end

  // conversion and overtemp registers
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cv_q <= 32'h0;
      temp_q <= 9'h000;
      fq_q <= 3'h0;
      act_q <= 1'b0;
      pend_q <= 1'b0;
      os_q <= 1'b1;
    end
    else
    begin
      cv_q <= cv_d;
      temp_q <= temp_d;
      fq_q <= fq_d;
      act_q <= act_d;
      pend_q <= pend_d;
      os_q <= os_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic sda_lo_q, busy_o_q;

  // sda data is always low; the enable alone decides the wire
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sda_lo_q <= 1'b0;
      busy_o_q <= 1'b0;
    end
    else
    begin
      sda_lo_q <= 1'b0;
      busy_o_q <= !busy_q && !shdn;
    end
  end

  assign sda_o = sda_lo_q;
  assign sda_oe_n_o = oe_n_q;
  assign os_o = os_q;
  assign temp_o = temp_q;
  assign conv_busy_o = busy_o_q;
endmodule

/* File: verilog/tsb_regs.svh */
// Contract
// [R1] Temperature reads return the last completed conversion, never a partial one.
// [R2] A serial access addressed to the sensor aborts the running conversion.
// [R3] After the transaction ends, a fresh conversion starts from the beginning.
// [R4] The temperature register updates only when a conversion runs to completion.
// [R5] Host should leave at least 300 ms idle between successive transactions.
// [R6] Overtemp asserts only after a programmable count of over-limit conversions, max 6.
// [R7] When SDA stays low past the timeout, serial state returns idle, SDA released.
// [R8] Stuck-low timeout lies between 75 ms and 325 ms; variants without it never time out.
// [R9] Power up loads overtemp and hysteresis limits with fixed defaults.
// [R10] Target address is 1001 followed by the three address select pins.
// [R11] Temperatures and limits are 9-bit two's complement, LSB is half a degree.
// [R12] Fault queue counts consecutive over-limit conversions; an in-limit one clears the count.
// [R13] In shutdown the bus timeout is disabled.
// [R14] Stuck-bus timer restarts when SDA is high, counts only while SDA stays low.
// [R15] Bus idle after stop ends communication and lets a new conversion start.
`ifndef TSB_REGS_SVH
`define TSB_REGS_SVH
// ----------------------------------------
// register pointer values
// ----------------------------------------
`define TSB_PTR_TEMP 2'h0
`define TSB_PTR_CFG 2'h1
`define TSB_PTR_THYST 2'h2
`define TSB_PTR_TOS 2'h3
// ----------------------------------------
// configuration fields
// ----------------------------------------
`define TSB_CFG_SHDN 0
`define TSB_CFG_INTM 1
`define TSB_CFG_POL 2
`define TSB_CFG_FQ_LO 3
`define TSB_CFG_FQ_HI 4
`define TSB_CFG_RST 8'h00
// ----------------------------------------
// reset values and address
// ----------------------------------------
`define TSB_TOS_RST 9'h0a0
`define TSB_THYST_RST 9'h096
`define TSB_ADDR_HI 4'h9
// ----------------------------------------
// timing, in nanoseconds and milliseconds, and the fault queue maximum
// ----------------------------------------
`define TSB_CLK_NS 4
`define TSB_NS_PER_MS 1000000
`define TSB_CONV_MS 100
`define TSB_TOUT_MIN_MS 75
`define TSB_TOUT_MAX_MS 325
`define TSB_FQ_MAX 6
`endif

/* File: verilog/tsb_pkg.sv */
package tsb_pkg;
  // serial target states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WBYTE,
    ST_WACK,
    ST_RBYTE,
    ST_RACK
  } tsb_state_t;
  typedef logic signed [8:0] tsb_temp_t;
endpackage

/* File: verilog/tsb_timeout.sv */
`timescale 1ns/10ps
`include "tsb_regs.svh"
module tsb_timeout #(
  parameter int unsigned TOUT_CYCLES = 32'd18750000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic enable_i,
  input wire logic sda_lvl_i,
  // event
  output logic expire_o
);
  logic [31:0] cnt_q, cnt_d;
  logic expire_d;

  // count only continuous low time; high or disable restarts from zero
  always_comb
  begin
    cnt_d = 32'h0;
    expire_d = 1'b0;
    if (enable_i && !sda_lvl_i) // see [R14] see [R13]
    begin
      // park one past the expiry count so a long low gives a single pulse
      if (cnt_q == TOUT_CYCLES)
        cnt_d = cnt_q;
      else
        cnt_d = cnt_q + 32'h1;
      if (cnt_q == TOUT_CYCLES - 32'h1)
        expire_d = 1'b1; // see [R8]
    end
  end

  // one pulse per expiry, then count again only after sda returns high or enable drops
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 32'h0;
      expire_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      expire_o <= expire_d;
    end
  end
endmodule

/* File: tb/tsb_props.sv */
`timescale 1ns/10ps
module tsb_props
  import tsb_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 200,
  parameter int unsigned TOUT_CYCLES = 300
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // data and status
  input wire tsb_pkg::tsb_temp_t adc_sample_i,
  input wire logic os_o,
  input wire tsb_pkg::tsb_temp_t temp_o,
  input wire logic conv_busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------
  // run-length counters
  // --------------------
  // both saturate so a long run can never wrap into a false pass
  int unsigned busy_d, busy_q, low_d, low_q;
  always_comb
  begin
    busy_d = conv_busy_o ? ((busy_q > CONV_CYCLES) ? busy_q : busy_q + 1) : 0;
    low_d = sda_i ? 0 : ((low_q > TOUT_CYCLES + 9) ? low_q : low_q + 1);
  end
  always_ff @(posedge mclk_i)
  begin
    busy_q <= sys_rst_i ? 0 : busy_d;
    low_q <= sys_rst_i ? 0 : low_d;
  end
  // --------------------
  // properties
  // --------------------
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  sequence s_drive_low;
    $fell(sda_oe_n_o);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> sda_oe_n_o && os_o && temp_o == 0)
    else $error("reset state wrong");
  a_temp_sample: assert property ($changed(temp_o) |-> temp_o == $past(adc_sample_i))
    else $error("temp not the sample");
  a_fresh_conv: assert property ($changed(temp_o) |-> busy_q >= CONV_CYCLES - 8)
    else $error("temp updated early");
  a_abort_addr: assert property (s_drive_low |-> ##[0:3] !conv_busy_o)
    else $error("conversion not aborted");
  a_stop_restart: assert property (s_stop |-> ##[1:8] conv_busy_o)
    else $error("no restart after stop");
  a_tout_release: assert property (low_q == TOUT_CYCLES + 8 |-> sda_oe_n_o)
    else $error("sda held past timeout");
  a_os_trip: assert property ($fell(os_o) |-> temp_o > 9'sh0a0)
    else $error("os set under limit");
  a_os_clear: assert property ($rose(os_o) |-> temp_o < 9'sh096)
    else $error("os cleared above limit");
  a_bit_stands: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
    else $error("sda moved while scl high");
  a_drive_zero: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("sda driven high");
endmodule
bind tsb_top tsb_props #(.CONV_CYCLES(CONV_CYCLES), .TOUT_CYCLES(TOUT_CYCLES)) tsb_props_i (.mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .adc_sample_i(adc_sample_i), .os_o(os_o), .temp_o(temp_o), .conv_busy_o(conv_busy_o));

/* File: tb/tsb_host.sv */
`timescale 1ns/10ps
module tsb_host (
  // clock and wire level
  input wire logic mclk_i,
  input wire logic sda_lvl_i,
  // open-drain drives, 1 is released
  output logic scl_o,
  output logic sda_o
);
  // --------------------
  // bus controller
  // --------------------
  // 32 ns bit: 20 low, 12 high, so the target's late answer lands before the rise
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic bit_x(input logic b, output logic r);
    scl_o <= 1'b0;
    cyc(1);
    sda_o <= b;
    cyc(4);
    scl_o <= 1'b1;
    r = sda_lvl_i;
    cyc(3);
  endtask
  task automatic start();
    sda_o <= 1'b0;
    cyc(4);
  endtask
  task automatic stop();
    scl_o <= 1'b0;
    cyc(1);
    sda_o <= 1'b0;
    cyc(4);
    scl_o <= 1'b1;
    cyc(4);
    sda_o <= 1'b1;
    cyc(8); // short idle gap, longer ones are up to the caller
  endtask
  // scl stalled low, for stuck-bus cases
  task automatic hold(input int n);
    scl_o <= 1'b0;
    cyc(n);
  endtask
  // scl stalled low with the controller itself pulling sda low
  task automatic low(input int n);
    scl_o <= 1'b0;
    cyc(1);
    sda_o <= 1'b0;
    cyc(n);
  endtask
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

/* File: tb/tsb_top_tb.sv */
`timescale 1ns/10ps
module tsb_top_tb;
  import tsb_pkg::*;
  localparam int CONV = 200;
  localparam int TOUT = 300;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] pins = 3'h0;
  tsb_temp_t adc = '0;
  tsb_temp_t temp_o, v, nv;
  logic scl, host_sda, sda_o, sda_oe_n_o, os_o, conv_busy_o, ack;
  wire logic sda_lvl = host_sda & (sda_oe_n_o | sda_o);
  logic [31:0] seed = 32'd71027;
  logic [15:0] w;
  int err_count = 0;
  int n_checks = 0;
  always #2 mclk_i = ~mclk_i;
  tsb_top #(.HAS_TIMEOUT(1'b1), .CONV_CYCLES(CONV), .TOUT_CYCLES(TOUT)) tsb_top_i (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_lvl), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .address_select_pins_i(pins), .adc_sample_i(adc), .os_o(os_o), .temp_o(temp_o), .conv_busy_o(conv_busy_o));
  tsb_host tsb_host_i (.mclk_i(mclk_i), .sda_lvl_i(sda_lvl), .scl_o(scl), .sda_o(host_sda));
  // --------------------
  // helpers
  // --------------------
  function automatic tsb_temp_t rnd_temp();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {seed[7], seed[7:0]};
  endfunction
  // read word: msb byte then bit 0 in the top of the lsb byte
  function automatic logic [15:0] word(input logic [8:0] t);
    return {t, 7'h00};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_temp(input tsb_temp_t t);
    int k;
    k = 0;
    while (temp_o !== t && k < 2 * CONV)
    begin
      @(posedge mclk_i);
      k++;
    end
    if (temp_o !== t)
    begin
      chk({7'h0, temp_o}, {7'h0, t});
      results();
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic one, input logic [7:0] d);
    tsb_host_i.start();
    tsb_host_i.byte_wr({4'h9, pins, 1'b0}, ack);
    chk(16'(ack), 16'h1);
    tsb_host_i.byte_wr({6'h0, p}, ack);
    if (one)
      tsb_host_i.byte_wr(d, ack);
    tsb_host_i.stop();
  endtask
  task automatic rd(output logic [15:0] d);
    tsb_host_i.start();
    tsb_host_i.byte_wr({4'h9, pins, 1'b1}, ack);
    tsb_host_i.byte_rd(1'b0, d[15:8]);
    tsb_host_i.byte_rd(1'b1, d[7:0]);
    tsb_host_i.stop();
  endtask
  // --------------------
  // main sequence
  // --------------------
  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    pins <= 3'(rnd_temp());
    v = rnd_temp() | 9'h001;
    adc <= v;
    @(posedge mclk_i);
    chk({14'h0, os_o, sda_oe_n_o}, 16'h3);
    wait_temp(v);
    // each read lands just after a conversion end, so the next one is cut off
    for (int i = 0; i < 4; i++)
    begin
      nv = rnd_temp();
      if (nv === v)
        nv = v ^ 9'h002;
      adc <= nv;
      rd(w);
      chk(w, word(v));
      tsb_host_i.cyc(CONV - 20);
      chk({7'h0, temp_o}, {7'h0, v});
      wait_temp(nv);
      v = nv;
    end
    for (int p = 2; p < 4; p++)
    begin
      wr(2'(p), 1'b0, 8'h00);
      rd(w);
      chk(w, word((p == 2) ? 9'h096 : 9'h0a0));
    end
    for (int i = 0; i < 2; i++)
    begin
      tsb_host_i.start();
      tsb_host_i.byte_wr(i ? {4'h9, pins ^ 3'h4, 1'b1} : {4'h8, pins, 1'b1}, ack);
      chk(16'(ack), 16'h0);
      tsb_host_i.stop();
    end
    // queue of six; the in-limit sample at step 5 must restart the count
    wr(2'h1, 1'b1, 8'h18);
    for (int i = 0; i < 12; i++)
    begin
      v = (i == 5) ? 9'h010 : ((i % 2) ? 9'h0a2 : 9'h0a1);
      adc <= v;
      wait_temp(v);
      tsb_host_i.cyc(2);
      chk(16'(os_o), (i == 11) ? 16'h0 : 16'h1);
    end
    // stall scl after the address: the target's own zero holds sda low
    tsb_host_i.start();
    tsb_host_i.byte_wr({4'h9, pins, 1'b1}, ack);
    tsb_host_i.hold(20);
    chk(16'(sda_oe_n_o), 16'h0);
    tsb_host_i.hold(TOUT - 60);
    chk(16'(sda_oe_n_o), 16'h0);
    tsb_host_i.hold(80);
    chk(16'(sda_oe_n_o), 16'h1);
    tsb_host_i.stop();
    // shutdown set and left inside one write; sda pinned low past the timeout in between,
    // so the target must still be in the write to take the byte that leaves shutdown
    tsb_host_i.start();
    tsb_host_i.byte_wr({4'h9, pins, 1'b0}, ack);
    tsb_host_i.byte_wr(8'h01, ack);
    tsb_host_i.byte_wr(8'h01, ack);
    tsb_host_i.low(TOUT + 80);
    tsb_host_i.byte_wr(8'h00, ack);
    chk(16'(ack), 16'h1);
    tsb_host_i.stop();
    // queue is one deep now: one sample under the hysteresis limit clears the output
    adc <= 9'h010;
    wait_temp(9'h010);
    tsb_host_i.cyc(2);
    chk(16'(os_o), 16'h1);
    results();
  end
endmodule
